// [rtl/sadc_pkg.sv]
// Package with constants and types of the serial converter control block
package sadc_pkg;

  // ****************************************
  // Conversion geometry
  // ****************************************
  localparam int RES_BITS = 12;
  localparam logic [RES_BITS-1:0] SAR_CLEAR = 12'h000;
  localparam logic [RES_BITS-1:0] MSB_WEIGHT = 12'h800;

  // ****************************************
  // Timing in ns and derived cycle counts at 100 MHz
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int ACQ_TIME_NS = 315;
  localparam int ACQ_CYCLES = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_PULSE_NS = 60;
  localparam int WAKE_CYCLES = (WAKE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 6;

  // ****************************************
  // Power-down request pulse counts
  // ****************************************
  localparam logic [2:0] LIGHT_PULSES = 3'h2;
  localparam logic [2:0] DEEP_PULSES = 3'h4;

  // ****************************************
  // Enumerations
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ACQ,
    ST_CONVERSION_START,
    ST_SHIFT
  } sadc_state_t;

  typedef enum logic [1:0] {
    PM_ACTIVE,
    PM_LIGHT,
    PM_DEEP
  } sadc_pmode_t;

endpackage

// [rtl/sadc_ctrl.sv]
// Control logic of a 12-bit successive-approximation converter with serial port
// Functional notes
// RQ1: Rising conversion_start edge begins a conversion
// RQ2: Approximation register cleared at conversion start
// RQ3: Start edges ignored while conversion runs
// RQ4: Bits resolved MSB down to LSB
// RQ5: Final register forms 12-bit serial result
// RQ6: Serial output advances with host clock
// RQ7: Acquisition phase of 315ns before converting
// RQ8: Clock high 60ns wakes from power-down
// RQ9: Two/four start pulses, clock low, power-down
// RQ10: Shutdown pin low forces shutdown, flag low
// RQ11: Power-down entered on final pulse fall
// RQ12: Device starts active after power-up
// RQ13: Result coded as straight binary
// RQ14: Host releases start early or late
// RQ15: Result shifted MSB first, one per clock
// RQ16: Host supplies enough clocks per conversion
`timescale 1ns/1ps

module sadc_ctrl (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Host serial port
  input wire logic host_clk,
  input wire logic conversion_start,
  output logic serial_result_out,
  output logic serial_out_en,
  // Shutdown pin
  input wire logic shutdown_pin_b,
  // Comparator from analog front end
  input wire logic cmp_above,
  output logic [11:0] dac_code,
  // Status
  output logic reference_settled_flag,
  output logic sampling,
  output logic converting,
  output logic light_powerdown,
  output logic deep_powerdown,
  output logic shutdown
);

  // ****************************************
  // Reset synchroniser
  // ****************************************
  logic rst_meta;
  logic rst_sync;

  // Two-stage release of the asynchronous reset
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // ****************************************
  // Edge detection of host pins
  // ****************************************
  logic conversion_start_d;
  logic hclk_d;
  logic conversion_start_rise;
  logic conversion_start_fall;
  logic hclk_rise;

  always_ff @(posedge ref_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      conversion_start_d <= 1'b0;
      hclk_d <= 1'b0;
    end else begin
      conversion_start_d <= conversion_start;
      hclk_d <= host_clk;
    end
  end

  // Single-cycle edge pulses
  assign conversion_start_rise = conversion_start & ~conversion_start_d;
  assign conversion_start_fall = ~conversion_start & conversion_start_d;
  assign hclk_rise = host_clk & ~hclk_d;

  // ****************************************
  // Power mode tracking
  // ****************************************
  sadc_pkg::sadc_pmode_t pmode;
  sadc_pkg::sadc_pmode_t next_pmode;
  logic [2:0] pulse_cnt;
  logic [2:0] next_pulse_cnt;
  logic [sadc_pkg::CNT_W-1:0] high_cnt;
  logic [sadc_pkg::CNT_W-1:0] next_high_cnt;
  logic wake;

  // Wake when the clock has stayed high long enough
  assign wake = host_clk &&
      (high_cnt >= sadc_pkg::CNT_W'(sadc_pkg::WAKE_CYCLES - 1)); // [RQ8]

  always_comb begin
    next_pmode = pmode;
    next_pulse_cnt = pulse_cnt;
    next_high_cnt = '0;
    if (host_clk && high_cnt != '1) begin
      next_high_cnt = high_cnt + 1'b1;
    end
    if (host_clk || !shutdown_pin_b) begin
      // A clock high phase or shutdown abandons a partial request
      next_pulse_cnt = 3'h0;
    end else if (conversion_start_fall) begin
      // Count pulses with clock low; the falling edge decides the mode
      next_pulse_cnt = pulse_cnt + 3'h1; // [RQ9]
      if (pulse_cnt + 3'h1 == sadc_pkg::LIGHT_PULSES) begin
        next_pmode = sadc_pkg::PM_LIGHT; // [RQ11]
      end else if (pulse_cnt + 3'h1 == sadc_pkg::DEEP_PULSES) begin
        next_pmode = sadc_pkg::PM_DEEP; // [RQ11]
        next_pulse_cnt = 3'h0;
      end
    end
    if (wake && pmode != sadc_pkg::PM_ACTIVE) begin
      next_pmode = sadc_pkg::PM_ACTIVE; // [RQ8]
    end
  end

  // Power-up lands in the active mode
  always_ff @(posedge ref_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      pmode <= sadc_pkg::PM_ACTIVE; // [RQ12]
      pulse_cnt <= 3'h0;
      high_cnt <= '0;
    end else begin
      pmode <= next_pmode;
      pulse_cnt <= next_pulse_cnt;
      high_cnt <= next_high_cnt;
    end
  end

  assign light_powerdown = (pmode == sadc_pkg::PM_LIGHT);
  assign deep_powerdown = (pmode == sadc_pkg::PM_DEEP);
  assign shutdown = ~shutdown_pin_b; // [RQ10]

  // ****************************************
  // Conversion sequencer
  // ****************************************
  sadc_pkg::sadc_state_t state;
  sadc_pkg::sadc_state_t next_state;
  logic [11:0] approximation_register;
  logic [11:0] next_approximation_register;
  logic [11:0] weight;
  logic [11:0] next_weight;
  logic [11:0] shift_reg;
  logic [11:0] next_shift_reg;
  logic [sadc_pkg::CNT_W-1:0] cnt;
  logic [sadc_pkg::CNT_W-1:0] next_cnt;
  logic sout;
  logic next_sout;
  logic oen;
  logic next_oen;
  logic ref_ok;
  logic next_ref_ok;
  logic can_start;

  // Starts are accepted only in the active mode with the shutdown pin high
  assign can_start = (pmode == sadc_pkg::PM_ACTIVE) && shutdown_pin_b;

  always_comb begin
    next_state = state;
    next_approximation_register = approximation_register;
    next_weight = weight;
    next_shift_reg = shift_reg;
    next_cnt = cnt;
    next_sout = sout;
    next_oen = oen;
    next_ref_ok = ref_ok;
    if (!shutdown_pin_b || deep_powerdown) begin
      next_ref_ok = 1'b0; // [RQ10]
    end else if (pmode == sadc_pkg::PM_ACTIVE) begin
      next_ref_ok = 1'b1;
    end
    case (state)
      sadc_pkg::ST_IDLE: begin
        // Only an idle sequencer reacts to a start edge
        if (conversion_start_rise && can_start) begin // [RQ1] [RQ3]
          next_state = sadc_pkg::ST_ACQ;
          next_cnt = '0;
          next_approximation_register = sadc_pkg::SAR_CLEAR; // [RQ2]
          next_weight = sadc_pkg::MSB_WEIGHT;
          next_oen = 1'b0;
        end
      end
      sadc_pkg::ST_ACQ: begin
        // Track the input for the acquisition time
        if (cnt == sadc_pkg::CNT_W'(sadc_pkg::ACQ_CYCLES - 1)) begin // [RQ7]
          next_state = sadc_pkg::ST_CONVERSION_START;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
      sadc_pkg::ST_CONVERSION_START: begin
        // One bit decision per host clock rise, trial bit set first
        if (hclk_rise) begin // [RQ4]
          if (cmp_above) begin
            next_approximation_register = approximation_register | weight;
          end
          next_weight = weight >> 1;
          if (weight[0]) begin
            next_state = sadc_pkg::ST_SHIFT;
            next_shift_reg = approximation_register | (cmp_above ? weight : 12'h000); // [RQ5]
            next_cnt = '0;
          end
        end
      end
      sadc_pkg::ST_SHIFT: begin
        // Straight binary word out MSB first, one bit per host clock rise
        if (hclk_rise) begin // [RQ6] [RQ15] [RQ13]
          if (cnt == sadc_pkg::CNT_W'(sadc_pkg::RES_BITS)) begin
            next_oen = 1'b0;
            next_state = sadc_pkg::ST_IDLE;
          end else begin
            next_sout = shift_reg[11];
            next_shift_reg = {shift_reg[10:0], 1'b0};
            next_oen = 1'b1;
            next_cnt = cnt + 1'b1;
          end
        end
      end
      default: begin
        next_state = sadc_pkg::ST_IDLE;
      end
    endcase
    // Shutdown and power-down both abort a conversion in flight
    if (!shutdown_pin_b || pmode != sadc_pkg::PM_ACTIVE) begin
      next_state = sadc_pkg::ST_IDLE;
      next_oen = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      state <= sadc_pkg::ST_IDLE;
      approximation_register <= 12'h000;
      weight <= 12'h000;
      shift_reg <= 12'h000;
      cnt <= '0;
      sout <= 1'b0;
      oen <= 1'b0;
      ref_ok <= 1'b0;
    end else begin
      state <= next_state;
      approximation_register <= next_approximation_register;
      weight <= next_weight;
      shift_reg <= next_shift_reg;
      cnt <= next_cnt;
      sout <= next_sout;
      oen <= next_oen;
      ref_ok <= next_ref_ok;
    end
  end

  assign serial_result_out = sout;
  assign serial_out_en = oen;
  assign dac_code = approximation_register | weight;
  assign reference_settled_flag = ref_ok;
  assign sampling = (state == sadc_pkg::ST_ACQ);
  assign converting = (state != sadc_pkg::ST_IDLE);

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_sync);

  a_start_clears: assert property (conversion_start_rise && can_start && state == sadc_pkg::ST_IDLE |=> // [RQ2]
      approximation_register == 12'h000 && state == sadc_pkg::ST_ACQ)
    else $error("start did not clear register");
  a_no_restart: assert property (sampling && conversion_start_rise && can_start |=> cnt != 6'h00) // [RQ3]
    else $error("conversion restarted");
  a_acq_length: assert property ($rose(sampling) |-> (sampling || !can_start) [*8] // [RQ7]
      ##1 (sampling || state == sadc_pkg::ST_CONVERSION_START || !can_start))
    else $error("acquisition too short");
  a_shutdown_pin_flag: assert property (!shutdown_pin_b |=> !reference_settled_flag) // [RQ10]
    else $error("flag high in shutdown");
  a_wake: assert property (host_clk [*6] |=> pmode == sadc_pkg::PM_ACTIVE) // [RQ8]
    else $error("no wake after clock pulse");
  a_msb_first: assert property (state == sadc_pkg::ST_SHIFT && hclk_rise && cnt == 6'h00 && // [RQ15]
      shutdown_pin_b |=> serial_result_out == $past(shift_reg[11]))
    else $error("first bit not msb");
  a_shift_sync: assert property (!hclk_rise && state == sadc_pkg::ST_SHIFT |=> // [RQ6]
      $stable(serial_result_out))
    else $error("output moved without clock");
  a_weight_walk: assert property (state == sadc_pkg::ST_CONVERSION_START && hclk_rise && shutdown_pin_b |=> // [RQ4]
      weight == ($past(weight) >> 1))
    else $error("weight not halved");
  a_deep_entry: assert property (!host_clk && conversion_start_fall && !converting && pulse_cnt == 3'h3 // [RQ11]
      && shutdown_pin_b |=> deep_powerdown)
    else $error("deep mode not entered");

  c_full_conversion_start: cover property (state == sadc_pkg::ST_SHIFT ##1 state == sadc_pkg::ST_IDLE);
  c_light: cover property ($rose(light_powerdown));
  c_deep: cover property ($rose(deep_powerdown));
  c_wake: cover property (light_powerdown ##1 !light_powerdown);

endmodule

// [verif/sadc_host.sv]
// Host serial port model driving the converter clock and start lines
`timescale 1ns/1ps

module sadc_host (
  // System clock
  input wire logic ref_clk,
  // Serial port
  output logic host_clk,
  output logic conversion_start,
  input wire logic serial_result_out,
  input wire logic serial_out_en
);
  // ****************************************
  // Host actions, all launched at falling edges
  // ****************************************
  initial begin
    host_clk = 1'b0;
    conversion_start = 1'b0;
  end

  // Wait a number of falling system clock edges
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // Short start pulse, released before the first bit decision
  task automatic pulse_start();
    conversion_start = 1'b1;
    idle(2);
    conversion_start = 1'b0;
    idle(2);
  endtask

  // Clock held high long enough to wake the device
  task automatic wake();
    host_clk = 1'b1;
    idle(8);
    host_clk = 1'b0;
    idle(2);
  endtask

  // Decisions, twelve result bits, one release clock; bit taken late in high phase
  task automatic frame(output logic [11:0] word, output int en_cnt);
    word = 12'h000;
    en_cnt = 0;
    for (int i = 0; i < 25; i++) begin
      host_clk = 1'b1;
      idle(5);
      if (i >= 12 && i < 24) word = {word[10:0], serial_result_out};
      if (serial_out_en === 1'b1) en_cnt++; // Cycles with the output driven
      host_clk = 1'b0; // Low half of every host clock period
      idle(5);
    end
  endtask
endmodule

// [verif/tb_top.sv]
// Self-checking testbench of the serial converter control block
`timescale 1ns/1ps

module tb_top;
  // ****************************************
  // Signals
  // ****************************************
  logic ref_clk, rst_b, host_clk, conversion_start, serial_result_out, serial_out_en;
  logic shutdown_pin_b, cmp_above, reference_settled_flag, sampling, converting;
  logic light_powerdown, deep_powerdown, shutdown;
  logic [11:0] dac_code;
  logic [11:0] vin;
  int miscompares, samples_checked, cycles, samp_run, samp_len;

  // Ideal comparator for the analog input level
  assign cmp_above = (vin >= dac_code);

  sadc_ctrl DUT (
    .ref_clk(ref_clk), .rst_b(rst_b), .host_clk(host_clk),
    .conversion_start(conversion_start), .serial_result_out(serial_result_out),
    .serial_out_en(serial_out_en), .shutdown_pin_b(shutdown_pin_b),
    .cmp_above(cmp_above), .dac_code(dac_code),
    .reference_settled_flag(reference_settled_flag), .sampling(sampling),
    .converting(converting), .light_powerdown(light_powerdown),
    .deep_powerdown(deep_powerdown), .shutdown(shutdown)
  );

  sadc_host host (
    .ref_clk(ref_clk), .host_clk(host_clk), .conversion_start(conversion_start),
    .serial_result_out(serial_result_out), .serial_out_en(serial_out_en)
  );

  // ****************************************
  // Clock, acquisition length monitor, timeout
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Length of the last sampling run in cycles
  always @(negedge ref_clk) begin
    cycles++;
    if (sampling === 1'b1) samp_run++;
    else if (samp_run != 0) begin
      samp_len = samp_run;
      samp_run = 0;
    end
    if (cycles == 8000) begin
      miscompares++;
      summarize();
    end
  end

  // ****************************************
  // Checking and reporting
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  // State straight after reset
  task automatic t_reset();
    check(light_powerdown, 1'b0, "light after reset");
    check(deep_powerdown, 1'b0, "deep after reset");
    check(converting, 1'b0, "busy after reset");
    check(reference_settled_flag, 1'b1, "flag after reset");
  endtask

  // One conversion, optionally with a second start edge during acquisition
  task automatic t_convert(input logic [11:0] v, input bit restart);
    logic [11:0] w;
    int en;
    vin = v;
    host.pulse_start();
    check(converting, 1'b1, "busy after start");
    // A clock pulse between starts keeps them from reading as a power-down request
    if (restart) begin
      host.wake();
      host.pulse_start();
    end
    host.idle(40);
    host.frame(w, en);
    check(w, v, "result word");
    check(en, 12, "output enable bits");
    check(samp_len, sadc_pkg::ACQ_CYCLES, "acquisition length");
    check(converting, 1'b0, "idle after frame");
  endtask

  // Power-down request by n start pulses with the clock low, then wake-up
  task automatic t_power(input int n, input bit deep);
    repeat (n - 1) host.pulse_start();
    check(deep ? deep_powerdown : light_powerdown, 1'b0, "mode before last fall");
    host.pulse_start();
    check(light_powerdown, !deep, "light mode");
    check(deep_powerdown, deep, "deep mode");
    host.pulse_start();
    check(converting, 1'b0, "start refused in power-down");
    host.wake();
    check({light_powerdown, deep_powerdown}, 2'h0, "awake");
  endtask

  // Shutdown pin low forces shutdown and refuses starts
  task automatic t_shutdown();
    shutdown_pin_b = 1'b0;
    host.idle(3);
    check(shutdown, 1'b1, "shutdown mode");
    check(reference_settled_flag, 1'b0, "flag in shutdown");
    host.pulse_start();
    check(converting, 1'b0, "start refused in shutdown");
    shutdown_pin_b = 1'b1;
    host.idle(4);
    check(shutdown, 1'b0, "shutdown left");
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_b = 1'b0;
    shutdown_pin_b = 1'b1;
    vin = 12'h000;
    host.idle(3);
    rst_b = 1'b1;
    host.idle(5);
    t_reset();
    t_convert(12'hfff, 1'b0);
    t_convert(12'h000, 1'b0);
    t_convert(12'ha5c, 1'b1);
    t_convert(12'h800, 1'b0);
    t_power(2, 1'b0);
    t_convert(12'h3c1, 1'b0);
    t_power(4, 1'b1);
    host.idle(10);
    t_shutdown();
    t_convert(12'h7ff, 1'b0);
    summarize();
  end
endmodule
